/* File: rtl/return_link_parser.sv */
// Receiver-side parser for return link transport packets
//
// How it works
// RL1 - Every packet opens with marker 0x47; parser hunts for it.
// RL2 - Fault flag one marks an errored packet; its contents are dropped.
// RL3 - Header order: flag, beacon, identifier, cipher, reserved, count, identity, payload.
// RL4 - The two reserved header bits are sent as binary 11.
// RL5 - Cipher 00 means clear payload; other codes are user defined.
// RL6 - Sequence count per identifier increments by one, wrapping modulo 16.
// RL7 - Target identity holds the intended transmitter address, or all zeros.
// RL8 - 92-byte payload: level, scheme indicator, then 90 private bytes.
// RL9 - Identifiers: 0x00-0x10 reserved, 0x11 feedback, 0x12 change, 0x13 echo, 0x1FFF null.
// RL10 - Power feedback arrives about every 200 ms from a timer.
// RL11 - Received level is signed eight-bit dBm.
// RL12 - Scheme codes 0..4 defined; 5..255 treated as unknown.
// RL13 - Multicarrier metrics: bandwidth, guard, constellation, rate, BERs, count, error ratio.
// RL14 - Guard interval 1/32..1/4 coded 00..11.
// RL15 - Multicarrier constellation QPSK 00, 16QAM 01, 64QAM 10.
// RL16 - Code rate 1/2..7/8 coded 000..100.
// RL17 - Each BER field: mantissa high byte, signed exponent low byte.
// RL18 - Uncorrectable count is a 16-bit unsigned raw count.
// RL19 - VSB metrics: noise byte, constellation, reserved bits, uncorrectable count.
// RL20 - Single carrier: noise, constellation, inner rate, uncorrectable count.
// RL21 - Change request command code 0..4 defined, 5..255 reserved.
// RL22 - Generic change request: signed excess power then scheme indicator.
// RL23 - Sender starts in beacon mode after reset.
// RL24 - Echo payload: watermark count byte, then 32-bit watermark values.
// RL25 - Sender fills idle time with null packets.
// RL26 - Unused payload bytes and reserved fields are sent as zero.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module return_link_parser
  import return_link_pkg::*;
#(
  parameter int CNT_W           = 16,
  parameter int STALE_CYCLES    = FEEDBACK_PERIOD_CYCLES * STALE_PERIODS,
  parameter int TIMER_W         = 32
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    in_valid,
  input  wire logic [7:0]              in_byte,
  input  wire return_link_pkg::sw_req_t sw_req,
  output logic [31:0]                  sw_rdata,
  output logic                         packet_done,
  output logic                         feedback_stale
);
  import return_link_pkg::*;

  if (CNT_W < 1 || CNT_W > 32 || TIMER_W < 8 || TIMER_W > 32 ||
      STALE_CYCLES < 1 || longint'(STALE_CYCLES) >= (longint'(1) << TIMER_W)) begin : g_bad
    $error("return_link_parser parameters out of range");
  end

  typedef enum logic [1:0] {HUNT, HEAD, BODY} parse_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Byte-at-offset extraction from captured payload, MSB-first
  function automatic logic [7:0] pbyte(input logic [CAP_MSB:0] cap, input int ofs);
    pbyte = cap[CAP_MSB - ofs -: 8];
  endfunction : pbyte

  function automatic logic [15:0] pword(input logic [CAP_MSB:0] cap, input int ofs);
    pword = cap[CAP_MSB - ofs -: 16];
  endfunction : pword

  // ----------------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------------
  parse_t             state, next_state;
  logic [6:0]         idx, next_idx;
  hdr_t               hdr, next_hdr;
  logic [CAP_MSB:0]   cap, next_cap;
  logic               in_sync, next_in_sync;
  logic               next_done;

  // Hunt for marker, shift header, capture leading payload bytes
  always_comb begin
    next_state   = state;
    next_idx     = idx;
    next_hdr     = hdr;
    next_cap     = cap;
    next_in_sync = in_sync;
    next_done    = 1'b0;
    if (in_valid) begin
      unique case (state)
        HUNT: begin
          if (in_byte == SYNC_MARKER) begin // RL1
            next_state = HEAD;
            next_idx   = 7'h01;
            next_cap   = '0;
          end else begin
            next_in_sync = 1'b0;
          end
        end
        HEAD: begin
          next_hdr = {hdr[$bits(hdr_t)-9:0], in_byte}; // RL3
          next_idx = 7'(idx + 7'h01);
          if (idx == LAST_HDR_IDX) begin
            next_state = BODY;
          end
        end
        BODY: begin
          // Only the leading bytes carry fields we decode
          if (idx < CAP_END_IDX) begin
            next_cap = {cap[CAP_MSB-8:0], in_byte}; // RL8
          end
          next_idx = 7'(idx + 7'h01);
          if (idx == LAST_PKT_IDX) begin
            next_state   = HUNT;
            next_in_sync = 1'b1;
            next_done    = 1'b1;
          end
        end
      endcase
    end
  end

  // Framing registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= HUNT;
      idx         <= 7'h00;
      hdr         <= '0;
      cap         <= '0;
      in_sync     <= 1'b0;
      packet_done <= 1'b0;
    end else begin
      state       <= next_state;
      idx         <= next_idx;
      hdr         <= next_hdr;
      cap         <= next_cap;
      in_sync     <= next_in_sync;
      packet_done <= next_done;
    end
  end

  // ----------------------------------------------------------------------
  // Packet classification
  // ----------------------------------------------------------------------
  logic [1:0]  ctrl;
  logic [31:0] own_id;
  logic        id_ok, accept, is_stream;
  logic [1:0]  stream;
  logic        gap;

  // Identity zero means unknown target and is always taken
  assign id_ok     = !ctrl[CTRL_FLT_BIT] || hdr.txid == 32'h0 || hdr.txid == own_id; // RL7
  assign accept    = packet_done && ctrl[CTRL_EN_BIT] && !hdr.fault && id_ok; // RL2
  assign is_stream = hdr.pid >= PID_FEEDBACK && hdr.pid <= PID_ECHO; // RL9
  assign stream    = 2'(hdr.pid - PID_FEEDBACK);

  // Null and reserved identifiers carry no counted stream
  seq_gap_check #(
    .STREAMS (3)
  ) seq_gap_check_i (
    .clk     (clk),
    .rst     (rst),
    .check   (accept && is_stream),
    .stream  (stream),
    .seq     (hdr.seq),
    .gap     (gap)
  );

  // ----------------------------------------------------------------------
  // Decoded results
  // ----------------------------------------------------------------------
  feedback_t   fb, next_fb;
  logic [23:0] cmd, next_cmd;
  logic [7:0]  wm_cnt, next_wm_cnt;
  logic [31:0] wm0, wm1, next_wm0, next_wm1;
  logic [7:0]  sts, next_sts;
  logic        fb_seen;
  logic [7:0]  scheme;

  assign scheme  = pbyte(cap, OFS_SCHEME);
  assign fb_seen = accept && hdr.pid == PID_FEEDBACK && hdr.cipher == CIPHER_CLEAR;

  // Decode payload by identifier, then by scheme code
  always_comb begin
    next_fb     = fb;
    next_cmd    = cmd;
    next_wm_cnt = wm_cnt;
    next_wm0    = wm0;
    next_wm1    = wm1;
    next_sts    = sts;
    if (packet_done) begin
      next_sts[5] = hdr.fault; // RL2
      next_sts[3] = hdr.rsv != RSV_HDR_BITS; // RL4
    end
    if (accept) begin
      next_sts[7:6] = hdr.beacon; // RL23
      next_sts[4]   = hdr.cipher != CIPHER_CLEAR; // RL5
    end
    if (fb_seen) begin
      next_fb        = '0;
      next_fb.level  = pbyte(cap, OFS_LEVEL); // RL11
      next_fb.scheme = scheme;
      next_sts[2]    = scheme > SCHEME_SC; // RL12
      unique case (scheme)
        SCHEME_MC: begin
          next_fb.bw         = cap[CAP_MSB - OFS_MC_BW -: 2]; // RL13
          next_fb.gi         = cap[CAP_MSB - OFS_MC_GI -: 2]; // RL14
          next_fb.con        = {1'b0, cap[CAP_MSB - OFS_MC_CON -: 2]}; // RL15
          next_fb.rate       = {1'b0, cap[CAP_MSB - OFS_MC_RATE -: 3]}; // RL16
          next_fb.ber_before = pword(cap, OFS_MC_BERB); // RL17
          next_fb.ber_after  = pword(cap, OFS_MC_BERA); // RL17
          next_fb.uce        = pword(cap, OFS_MC_UCE); // RL18
          next_fb.quality    = pbyte(cap, OFS_MC_EVR); // RL13
        end
        SCHEME_VSB: begin
          next_fb.quality = pbyte(cap, OFS_NOISE); // RL19
          next_fb.con     = cap[CAP_MSB - OFS_CON3 -: 3]; // RL19
          next_fb.uce     = pword(cap, OFS_VSB_UCE); // RL19
        end
        SCHEME_SC: begin
          next_fb.quality = pbyte(cap, OFS_NOISE); // RL20
          next_fb.con     = cap[CAP_MSB - OFS_CON3 -: 3]; // RL20
          next_fb.rate    = cap[CAP_MSB - OFS_SC_RATE -: 4]; // RL20
          next_fb.uce     = pword(cap, OFS_SC_UCE); // RL20
        end
        default: begin
          // Undetermined, FM and unknown codes carry level and scheme only
          next_fb.uce = 16'h0000;
        end
      endcase
    end
    if (accept && hdr.cipher == CIPHER_CLEAR && hdr.pid == PID_CHANGE) begin
      next_cmd    = {pbyte(cap, OFS_CMD), 16'h0000};
      next_sts[1] = pbyte(cap, OFS_CMD) > SCHEME_SC; // RL21
      if (pbyte(cap, OFS_CMD) == CMD_GENERIC) begin
        next_cmd[15:0] = {pbyte(cap, OFS_CMD_PWR), pbyte(cap, OFS_CMD_SCH)}; // RL22
      end
    end
    if (accept && hdr.cipher == CIPHER_CLEAR && hdr.pid == PID_ECHO) begin
      next_wm_cnt = pbyte(cap, OFS_WM_CNT); // RL24
      next_wm0    = (pbyte(cap, OFS_WM_CNT) > 8'h00) ? cap[CAP_MSB - OFS_WM0 -: 32] : 32'h0;
      next_wm1    = (pbyte(cap, OFS_WM_CNT) > 8'h01) ? cap[CAP_MSB - OFS_WM0 - 32 -: 32] : 32'h0;
    end
  end

  // Decoded result registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb     <= '0;
      cmd    <= '0;
      wm_cnt <= 8'h00;
      wm0    <= 32'h0;
      wm1    <= 32'h0;
      sts    <= 8'h00;
    end else begin
      fb     <= next_fb;
      cmd    <= next_cmd;
      wm_cnt <= next_wm_cnt;
      wm0    <= next_wm0;
      wm1    <= next_wm1;
      sts    <= next_sts;
    end
  end

  // ----------------------------------------------------------------------
  // Feedback watchdog and counters
  // ----------------------------------------------------------------------
  localparam logic [TIMER_W-1:0] STALE_LIMIT = TIMER_W'(STALE_CYCLES);

  logic [TIMER_W-1:0] age, next_age;
  logic [CNT_W-1:0]   good_cnt, err_cnt, disc_cnt;
  logic [CNT_W-1:0]   next_good_cnt, next_err_cnt, next_disc_cnt;
  logic               clr_cnt;
  logic               next_stale;

  assign clr_cnt = sw_req.wr && sw_req.addr == REG_GOOD_CNT;

  // A missing feedback packet for several periods marks the link stale
  always_comb begin
    next_age   = age;
    next_stale = feedback_stale;
    if (fb_seen) begin
      next_age   = '0; // RL10
      next_stale = 1'b0;
    end else if (age < STALE_LIMIT) begin
      next_age = TIMER_W'(age + 1'b1);
    end else begin
      next_stale = 1'b1; // RL10
    end
    // Clear first so an event in the same cycle still counts
    next_good_cnt = clr_cnt ? '0 : good_cnt;
    next_err_cnt  = clr_cnt ? '0 : err_cnt;
    next_disc_cnt = clr_cnt ? '0 : disc_cnt;
    if (accept && hdr.pid != PID_NULL) begin // RL25
      next_good_cnt = CNT_W'(next_good_cnt + 1'b1);
    end
    if (packet_done && hdr.fault) begin
      next_err_cnt = CNT_W'(next_err_cnt + 1'b1); // RL2
    end
    if (gap) begin
      next_disc_cnt = CNT_W'(next_disc_cnt + 1'b1); // RL6
    end
  end

  // Watchdog and counter registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age            <= '0;
      feedback_stale <= 1'b1;
      good_cnt       <= '0;
      err_cnt        <= '0;
      disc_cnt       <= '0;
    end else begin
      age            <= next_age;
      feedback_stale <= next_stale;
      good_cnt       <= next_good_cnt;
      err_cnt        <= next_err_cnt;
      disc_cnt       <= next_disc_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  logic [1:0]  next_ctrl;
  logic [31:0] next_own_id, next_rdata;

  // Writes steer filtering; reads answer in the following cycle only
  always_comb begin
    next_ctrl   = ctrl;
    next_own_id = own_id;
    next_rdata  = 32'h0;
    if (sw_req.wr && sw_req.addr == REG_CTRL) begin
      next_ctrl = sw_req.wdata[1:0];
    end
    if (sw_req.wr && sw_req.addr == REG_OWN_ID) begin
      next_own_id = sw_req.wdata;
    end
    if (sw_req.rd) begin
      unique case (sw_req.addr)
        REG_CTRL:     next_rdata = {30'h0, ctrl};
        REG_OWN_ID:   next_rdata = own_id;
        REG_STATUS:   next_rdata = {22'h0, feedback_stale, in_sync, sts};
        REG_GOOD_CNT: next_rdata = 32'(good_cnt);
        REG_ERR_CNT:  next_rdata = 32'(err_cnt);
        REG_DISC_CNT: next_rdata = 32'(disc_cnt);
        REG_FB_LINK:  next_rdata = {fb.level, fb.scheme, fb.quality, fb.bw, fb.gi, fb.con, fb.rate[3:3]};
        REG_FB_BER:   next_rdata = {fb.ber_before, fb.ber_after};
        REG_FB_UCE:   next_rdata = {13'h0, fb.rate[2:0], fb.uce};
        REG_CMD:      next_rdata = {8'h00, cmd};
        REG_WM_CNT:   next_rdata = {24'h0, wm_cnt};
        REG_WM0:      next_rdata = wm0;
        REG_WM1:      next_rdata = wm1;
        REG_HDR:      next_rdata = {hdr.fault, hdr.beacon, hdr.pid, hdr.cipher, hdr.rsv, hdr.seq, 8'h00};
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= CTRL_RESET;
      own_id   <= 32'h0;
      sw_rdata <= 32'h0;
    end else begin
      ctrl     <= next_ctrl;
      own_id   <= next_own_id;
      sw_rdata <= next_rdata;
    end
  end

endmodule : return_link_parser

/* File: rtl/return_link_pkg.sv */
// Shared constants and carriers of the return link packet parser
package return_link_pkg;

  // ----------------------------------------------------------------------
  // Packet framing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SYNC_MARKER    = 8'h47;
  localparam logic [1:0]  RSV_HDR_BITS   = 2'h3;
  localparam logic [1:0]  CIPHER_CLEAR   = 2'h0;
  localparam int          HDR_BYTES      = 8;
  localparam int          PAY_BYTES      = 92;
  localparam int          PKT_BYTES      = HDR_BYTES + PAY_BYTES;
  localparam int          CAP_BYTES      = 12;
  localparam int          CAP_MSB        = CAP_BYTES * 8 - 1;
  localparam logic [6:0]  LAST_HDR_IDX   = 7'(HDR_BYTES - 1);
  localparam logic [6:0]  LAST_PKT_IDX   = 7'(PKT_BYTES - 1);
  localparam logic [6:0]  CAP_END_IDX    = 7'(HDR_BYTES + CAP_BYTES);

  // ----------------------------------------------------------------------
  // Packet identifiers
  // ----------------------------------------------------------------------
  localparam logic [12:0] PID_RSV_MAX    = 13'h0010;
  localparam logic [12:0] PID_FEEDBACK   = 13'h0011;
  localparam logic [12:0] PID_CHANGE     = 13'h0012;
  localparam logic [12:0] PID_ECHO       = 13'h0013;
  localparam logic [12:0] PID_NULL       = 13'h1fff;

  // ----------------------------------------------------------------------
  // Scheme and command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SCHEME_UNDET   = 8'h00;
  localparam logic [7:0]  SCHEME_FM      = 8'h01;
  localparam logic [7:0]  SCHEME_MC      = 8'h02;
  localparam logic [7:0]  SCHEME_VSB     = 8'h03;
  localparam logic [7:0]  SCHEME_SC      = 8'h04;
  localparam logic [7:0]  CMD_GENERIC    = 8'h00;

  // ----------------------------------------------------------------------
  // Payload field positions, bits counted from the first payload bit
  // ----------------------------------------------------------------------
  localparam int OFS_LEVEL   = 0;
  localparam int OFS_SCHEME  = 8;
  localparam int OFS_MC_BW   = 16;
  localparam int OFS_MC_GI   = 18;
  localparam int OFS_MC_CON  = 20;
  localparam int OFS_MC_RATE = 22;
  localparam int OFS_MC_BERB = 32;
  localparam int OFS_MC_BERA = 48;
  localparam int OFS_MC_UCE  = 64;
  localparam int OFS_MC_EVR  = 80;
  localparam int OFS_NOISE   = 16;
  localparam int OFS_CON3    = 24;
  localparam int OFS_VSB_UCE = 72;
  localparam int OFS_SC_RATE = 40;
  localparam int OFS_SC_UCE  = 70;
  localparam int OFS_CMD     = 0;
  localparam int OFS_CMD_PWR = 8;
  localparam int OFS_CMD_SCH = 16;
  localparam int OFS_WM_CNT  = 0;
  localparam int OFS_WM0     = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ                 = 25_000_000;
  localparam int FEEDBACK_PERIOD_MS     = 200;
  localparam int FEEDBACK_PERIOD_CYCLES = CLK_HZ / 1000 * FEEDBACK_PERIOD_MS;
  localparam int STALE_PERIODS          = 3;

  // ----------------------------------------------------------------------
  // Software register map (word index)
  // ----------------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_OWN_ID   = 4'h1;
  localparam logic [3:0]  REG_STATUS   = 4'h2;
  localparam logic [3:0]  REG_GOOD_CNT = 4'h3;
  localparam logic [3:0]  REG_ERR_CNT  = 4'h4;
  localparam logic [3:0]  REG_DISC_CNT = 4'h5;
  localparam logic [3:0]  REG_FB_LINK  = 4'h6;
  localparam logic [3:0]  REG_FB_BER   = 4'h7;
  localparam logic [3:0]  REG_FB_UCE   = 4'h8;
  localparam logic [3:0]  REG_CMD      = 4'h9;
  localparam logic [3:0]  REG_WM_CNT   = 4'ha;
  localparam logic [3:0]  REG_WM0      = 4'hb;
  localparam logic [3:0]  REG_WM1      = 4'hc;
  localparam logic [3:0]  REG_HDR      = 4'hd;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_FLT_BIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h1;

  // Header in wire order, most significant field first
  typedef struct packed {
    logic        fault;
    logic [1:0]  beacon;
    logic [12:0] pid;
    logic [1:0]  cipher;
    logic [1:0]  rsv;
    logic [3:0]  seq;
    logic [31:0] txid;
  } hdr_t;

  // Decoded power feedback metrics
  typedef struct packed {
    logic [7:0]  level;
    logic [7:0]  scheme;
    logic [7:0]  quality;
    logic [1:0]  bw;
    logic [1:0]  gi;
    logic [2:0]  con;
    logic [3:0]  rate;
    logic [15:0] ber_before;
    logic [15:0] ber_after;
    logic [15:0] uce;
  } feedback_t;

  // Software command port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } sw_req_t;

endpackage : return_link_pkg

/* File: rtl/seq_gap_check.sv */
// Per-identifier sequence count tracker for received packets
`timescale 1ns/10ps
module seq_gap_check #(
  parameter int STREAMS = 3
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       check,
  input  wire logic [$clog2(STREAMS)-1:0] stream,
  input  wire logic [3:0]                 seq,
  output logic                            gap
);
  import return_link_pkg::*;

  if (STREAMS < 2) begin : g_bad
    $error("seq_gap_check needs at least two streams");
  end

  logic [3:0]         last [STREAMS];
  logic [STREAMS-1:0] seen;
  logic [3:0]         next_last [STREAMS];
  logic [STREAMS-1:0] next_seen;
  logic               next_gap;

  // Expected count is last plus one modulo sixteen; first packet only seeds
  always_comb begin
    next_last = last;
    next_seen = seen;
    next_gap  = 1'b0;
    if (check) begin
      next_gap          = seen[stream] && (seq != 4'(last[stream] + 4'h1)); // RL6
      next_last[stream] = seq;
      next_seen[stream] = 1'b1;
    end
  end

  // Table and gap pulse registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STREAMS; i++) begin
        last[i] <= 4'h0;
      end
      seen <= '0;
      gap  <= 1'b0;
    end else begin
      last <= next_last;
      seen <= next_seen;
      gap  <= next_gap;
    end
  end

endmodule : seq_gap_check

/* File: tb/packet_sender.sv */
// Far-end packet source model feeding the return link parser
`timescale 1ns/10ps
module packet_sender
  import return_link_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        fault,
  input  wire logic        slow,
  input  wire logic [12:0] pid,
  input  wire logic [95:0] pay,
  output logic             in_valid,
  output logic [7:0]       in_byte
);
  logic [3:0]   seq [4];
  logic [799:0] frame;
  logic [6:0]   idx;
  logic         busy;
  logic         hold;
  // Frame loaded whole at go, then a byte per slot; counts indexed by low pid bits
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      hold <= 1'b0;
      idx <= 7'h0;
      in_valid <= 1'b0;
      in_byte <= 8'h00;
      seq <= '{default: 4'h0};
    end else if (go && !busy) begin
      frame <= {SYNC_MARKER, fault, 2'h0, pid, CIPHER_CLEAR, RSV_HDR_BITS,
                seq[pid[1:0]], 32'h0, pay, 640'h0};
      seq[pid[1:0]] <= seq[pid[1:0]] + 4'h1;
      busy <= 1'b1;
      idx <= 7'h0;
      in_valid <= 1'b0;
    end else if (busy && !(slow && hold)) begin
      in_valid <= 1'b1;
      in_byte <= frame[799:792];
      frame <= {frame[791:0], 8'h00};
      idx <= idx + 7'h1;
      busy <= idx != 7'h63;
      hold <= 1'b1;
    end else begin
      // Idle line flips so an old byte is never mistaken for data
      in_valid <= 1'b0;
      in_byte <= ~in_byte;
      hold <= 1'b0;
    end
  end
endmodule : packet_sender

/* File: tb/return_link_parser_properties.sv */
// Port checker for the return link parser
`timescale 1ns/10ps
module return_link_parser_properties
  import return_link_pkg::*;
#(
  parameter int STALE_CYCLES = 200
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     in_valid,
  input wire logic [7:0]               in_byte,
  input wire return_link_pkg::sw_req_t sw_req,
  input wire logic [31:0]              sw_rdata,
  input wire logic                     packet_done,
  input wire logic                     feedback_stale
);
  logic [7:0] nbytes;
  logic [7:0] next_nbytes;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bytes taken since the last packet end; saturates so a long hunt cannot wrap
  always_comb begin
    next_nbytes = packet_done ? 8'(in_valid) : nbytes + 8'(in_valid && nbytes != 8'hff);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nbytes <= 8'h00;
    end else begin
      nbytes <= next_nbytes;
    end
  end
  rdata_idle_a: assert property (!sw_req.rd |=> sw_rdata == 32'h0) else $error("read data outside a read");
  done_single_a: assert property (packet_done |=> (!packet_done)[*8]) else $error("done too close");
  done_bytes_a: assert property (packet_done |-> nbytes >= 8'h64) else $error("short packet");
  done_byte_a: assert property (packet_done |-> $past(in_valid)) else $error("done without byte");
  stale_reset_a: assert property ($past(rst) |-> feedback_stale) else $error("fresh after reset");
  stale_fall_a: assert property ($fell(feedback_stale) |-> $past(packet_done))
    else $error("stale cleared without packet");
  stale_read_a: assert property (sw_req.rd && sw_req.addr == REG_STATUS |=>
    sw_rdata[9] == $past(feedback_stale)) else $error("stale bit mismatch");
  cmd_read_a: assert property (sw_req.rd && sw_req.addr == REG_CMD |=> sw_rdata[31:24] == 8'h00 &&
    (sw_rdata[23:16] == CMD_GENERIC || sw_rdata[15:0] == 16'h0)) else $error("command word malformed");
endmodule : return_link_parser_properties

bind return_link_parser return_link_parser_properties #(.STALE_CYCLES(STALE_CYCLES)) return_link_parser_properties_i (
  .clk(clk), .rst(rst), .in_valid(in_valid), .in_byte(in_byte), .sw_req(sw_req),
  .sw_rdata(sw_rdata), .packet_done(packet_done), .feedback_stale(feedback_stale));

/* File: tb/return_link_parser_test.sv */
// Self-checking bench for the return link parser
`timescale 1ns/10ps
module return_link_parser_test;
  import return_link_pkg::*;
  logic        clk, in_valid, packet_done, feedback_stale;
  logic        rst = 1'b1, go = 1'b0, fault = 1'b0, slow = 1'b1;
  logic [7:0]  in_byte;
  logic [12:0] pid = '0;
  logic [95:0] pay = '0;
  logic [31:0] sw_rdata;
  sw_req_t     sw_req = '0;
  int          fails = 0, checks_done = 0, s;
  return_link_parser #(.STALE_CYCLES(200)) return_link_parser_i (.clk(clk), .rst(rst), .in_valid(in_valid),
    .in_byte(in_byte), .sw_req(sw_req), .sw_rdata(sw_rdata), .packet_done(packet_done),
    .feedback_stale(feedback_stale));
  packet_sender packet_sender_i (.clk(clk), .rst(rst), .go(go), .fault(fault), .slow(slow), .pid(pid),
    .pay(pay), .in_valid(in_valid), .in_byte(in_byte));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Strobe cycle then an idle cycle, so no signal is driven twice at one edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    sw_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    sw_req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    sw_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    sw_req <= '0;
    #1 cmp(sw_rdata, exp);
    @(posedge clk);
  endtask : rd
  // Start one packet and wait, bounded, for its end pulse
  task automatic send(input logic [12:0] p, input logic f, input logic [95:0] d);
    int n;
    pid <= p;
    fault <= f;
    pay <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 500 && packet_done !== 1'b1; n++) @(posedge clk);
    if (n == 500) begin
      fails++;
      $display("Error at %0t: no packet end", $time);
      test_done();
    end
  endtask : send
  // Tests as sequences of packet and register calls
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_STATUS, 32'h200);
    rd(4'hf, 32'h0);
    $display("reset test done");
    send(PID_FEEDBACK, 1'b0, 96'hec02ba0002fa01f901001e00);
    slow <= 1'b0;
    rd(REG_FB_LINK, 32'hec021eb4);
    rd(REG_FB_BER, 32'h02fa01f9);
    rd(REG_FB_UCE, 32'h00040100);
    rd(REG_HDR, 32'h00113000);
    for (s = 17; s >= 0; s--) begin
      send(PID_FEEDBACK, 1'b0, {8'hec, 8'(s % 6), 80'h0});
      rd(REG_STATUS, s % 6 == 5 ? 32'h104 : 32'h100);
    end
    send(PID_FEEDBACK, 1'b0, 96'hec0416600050000002000400);
    rd(REG_FB_LINK, 32'hec041606);
    rd(REG_FB_UCE, 32'h00058001);
    send(PID_FEEDBACK, 1'b0, 96'hec0316800000000000123400);
    rd(REG_FB_LINK, 32'hec031608);
    rd(REG_FB_UCE, 32'h00001234);
    send(PID_ECHO, 1'b0, {8'h01, 32'h1234abcd, 32'h0badf00d, 24'h0});
    rd(REG_WM_CNT, 32'h1);
    rd(REG_WM0, 32'h1234abcd);
    rd(REG_WM1, 32'h0);
    rd(REG_DISC_CNT, 32'h0);
    $display("feedback test done");
    for (s = 5; s >= 0; s--) begin
      send(PID_CHANGE, 1'b0, {8'(s), 8'hfb, 8'h03, 72'h0});
      rd(REG_CMD, s == 0 ? 32'h0000fb03 : {8'h0, 8'(s), 16'h0});
    end
    send(PID_NULL, 1'b1, 96'h0);
    rd(REG_ERR_CNT, 32'h1);
    rd(REG_GOOD_CNT, 32'h1c);
    wr(REG_GOOD_CNT, 32'h0);
    rd(REG_ERR_CNT, 32'h0);
    $display("command test done");
    send(PID_FEEDBACK, 1'b1, 96'h0);
    send(PID_FEEDBACK, 1'b0, 96'h0);
    #1 cmp({31'h0, feedback_stale}, 32'h0);
    repeat (250) @(posedge clk);
    cmp({31'h0, feedback_stale}, 32'h1);
    rd(REG_DISC_CNT, 32'h1);
    $display("stale test done");
    test_done();
  end
endmodule : return_link_parser_test
